// ==== logic/gpio_pin_pkg.sv ====
// Functional notes
// - data pins act as GPIO only with chip enable low and no serial-mode lock
// - input-pin mode is bits 1:0 of config byte 0x439
// - mode 0: plain non-inverting input with pull-down enabled
// - mode 1: pull-up enabled only while a logging event runs
// - mode 2: pull-up in wait state; falling edge starts logging
// - mode 2 with timed start: delay expiry or falling edge, first wins
// - mode 3: pull-up while running; each falling edge triggers one logging event
// - chip enable high: output pin is serial data output only
// - output settings apply only with chip enable low, no serial-mode lock and application mode
// - output drive is bits 5:4 of config byte 0x439
// - drive 0 push-pull, also serial mode; drive 1 pull-up output
// - drive 2 pull-down output, pin level inverted from source
// - drive 3 high impedance, reset default
// - output source select is bits 7:6 of config byte 0x439
// - source 0 copies external interrupt comparator
// - source 1 high while an RF command is being processed
// - source 2 high while RF reader field present
// - source 3 is OR of four error flags
// - blink option gates flag OR: 32 high, 992 low oscillator counts
package gpio_pin_pkg;

   localparam int ADDR_W = 11;
   localparam logic [ADDR_W-1:0] GPIO_PIN_CONFIG_ADDR = 11'h439;

   // ---------------------------------------------------------------
   // config byte layout
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [1:0] output_source_select;
      logic [1:0] output_pin_drive;
      logic [1:0] spare;
      logic [1:0] input_pin_mode;
   } gpio_config_s;

   localparam gpio_config_s GPIO_PIN_CONFIG_RESET = 8'h30;

   localparam logic [1:0] IN_MODE_PULLDOWN = 2'h0;
   localparam logic [1:0] IN_MODE_EVENT_PULLUP = 2'h1;
   localparam logic [1:0] IN_MODE_START = 2'h2;
   localparam logic [1:0] IN_MODE_TRIGGER = 2'h3;

   localparam logic [1:0] DRIVE_PUSH_PULL = 2'h0;
   localparam logic [1:0] DRIVE_PULL_UP = 2'h1;
   localparam logic [1:0] DRIVE_PULL_DOWN = 2'h2;
   localparam logic [1:0] DRIVE_HIGH_Z = 2'h3;

   localparam logic [1:0] SRC_COMPARATOR = 2'h0;
   localparam logic [1:0] SRC_RF_COMMAND = 2'h1;
   localparam logic [1:0] SRC_RF_FIELD = 2'h2;
   localparam logic [1:0] SRC_ERROR_FLAGS = 2'h3;

   // ---------------------------------------------------------------
   // blink pattern in kilohertz oscillator counts
   // ---------------------------------------------------------------
   localparam int BLINK_HIGH_COUNTS = 32;
   localparam int BLINK_LOW_COUNTS = 992;
   localparam int BLINK_PERIOD = BLINK_HIGH_COUNTS + BLINK_LOW_COUNTS;

   typedef struct packed {
      logic memory_full_flag;
      logic conversion_error_flag;
      logic low_battery_flag;
      logic over_limit_flag;
   } error_flags_s;

   typedef enum logic [1:0] {
      LOGGER_OTHER,
      LOGGER_WAIT,
      LOGGER_RUNNING
   } logger_state_e;

endpackage

// ==== logic/spi_pin_gpio_control.sv ====
`timescale 1ns/10ps
module spi_pin_gpio_control #(
   parameter int BLINK_CNT_W = 10
) (
   input wire logic core_clk,
   input wire logic resetn,
   // config byte write/read port
   input wire logic cfg_wr_en,
   input wire logic cfg_rd_en,
   input wire logic [gpio_pin_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_rvalid,
   // mode context from the rest of the chip
   input wire logic chip_enable_pin,
   input wire logic serial_mode_lock,
   input wire logic application_mode,
   input wire gpio_pin_pkg::logger_state_e logger_state,
   input wire logic logging_event_busy,
   input wire logic timed_start_enable,
   input wire logic start_delay_expired,
   input wire logic blink_enable,
   input wire logic kilohertz_oscillator,
   // output sources
   input wire logic comparator_out,
   input wire logic rf_command_busy,
   input wire logic rf_field_present,
   input wire gpio_pin_pkg::error_flags_s error_flags,
   // serial port data output
   input wire logic spi_dout_data,
   input wire logic spi_dout_oe,
   // input pin
   input wire logic din_pin,
   output logic din_pullup_en,
   output logic din_pulldown_en,
   // output pin
   output logic dout_o,
   output logic dout_oe,
   output logic dout_pullup_en,
   output logic dout_pulldown_en,
   // logger triggers
   output logic start_logging,
   output logic log_event_trigger,
   output logic gpio_active
);
   import gpio_pin_pkg::*;

   // refused at elaboration: a narrower counter could not reach the period end
   if (BLINK_CNT_W < $clog2(BLINK_PERIOD)) begin : g_blink_width_check
      $error("blink counter too narrow");
   end

   localparam logic [BLINK_CNT_W-1:0] BLINK_HIGH_CNT = BLINK_CNT_W'(BLINK_HIGH_COUNTS);
   localparam logic [BLINK_CNT_W-1:0] BLINK_LAST_CNT = BLINK_CNT_W'(BLINK_PERIOD - 1);

   function automatic logic falling(input logic prev, input logic cur);
      falling = prev & ~cur;
   endfunction

   // ---------------------------------------------------------------
   // config byte
   // ---------------------------------------------------------------
   gpio_config_s config_reg, config_next;
   logic [7:0] rdata_reg, rdata_next;
   logic rvalid_reg, rvalid_next;
   logic cfg_hit;

   assign cfg_hit = (cfg_addr == GPIO_PIN_CONFIG_ADDR);

   always_comb begin
      config_next = config_reg;
      rdata_next = rdata_reg;
      rvalid_next = cfg_rd_en;
      if (cfg_wr_en && cfg_hit) begin
         config_next = gpio_config_s'(cfg_wdata);
      end
      if (cfg_rd_en) begin
         rdata_next = cfg_hit ? 8'(config_reg) : 8'h00;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         config_reg <= GPIO_PIN_CONFIG_RESET;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
      end else begin
         config_reg <= config_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   assign cfg_rdata = rdata_reg;
   assign cfg_rvalid = rvalid_reg;

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   // first stage of each chain is read only by its second stage
   logic [3:0] sync1_reg, sync1_next;
   logic [3:0] sync2_reg, sync2_next;
   logic din_prev_reg, din_prev_next;
   logic ce_s, din_s, comp_s, field_s;

   always_comb begin
      sync1_next = {chip_enable_pin, din_pin, comparator_out, rf_field_present};
      sync2_next = sync1_reg;
      din_prev_next = din_s;
   end

   // din idles high so no false edge after reset
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg <= 4'h4;
         sync2_reg <= 4'h4;
         din_prev_reg <= 1'b1;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         din_prev_reg <= din_prev_next;
      end
   end

   assign {ce_s, din_s, comp_s, field_s} = sync2_reg;

   // ---------------------------------------------------------------
   // input pin function
   // ---------------------------------------------------------------
   logic gpio_en;
   logic din_fall;
   logic pu_next, pd_next, start_next, trig_next;
   logic pu_reg, pd_reg, start_reg, trig_reg;

   // gpio only when deselected and not locked
   assign gpio_en = ~ce_s & ~serial_mode_lock;
   assign din_fall = falling(din_prev_reg, din_s);

   always_comb begin
      pu_next = 1'b0;
      pd_next = 1'b0;
      start_next = 1'b0;
      trig_next = 1'b0;
      if (gpio_en) begin
         unique case (config_reg.input_pin_mode)
            IN_MODE_PULLDOWN: begin
               pd_next = 1'b1;
            end
            IN_MODE_EVENT_PULLUP: begin
               pu_next = logging_event_busy;
            end
            IN_MODE_START: begin
               pu_next = (logger_state == LOGGER_WAIT);
               start_next = (logger_state == LOGGER_WAIT) &&
                            (din_fall || (timed_start_enable && start_delay_expired));
            end
            IN_MODE_TRIGGER: begin
               pu_next = (logger_state == LOGGER_RUNNING);
               trig_next = (logger_state == LOGGER_RUNNING) && din_fall;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         pu_reg <= 1'b0;
         pd_reg <= 1'b0;
         start_reg <= 1'b0;
         trig_reg <= 1'b0;
      end else begin
         pu_reg <= pu_next;
         pd_reg <= pd_next;
         start_reg <= start_next;
         trig_reg <= trig_next;
      end
   end

   assign din_pullup_en = pu_reg;
   assign din_pulldown_en = pd_reg;
   assign start_logging = start_reg;
   assign log_event_trigger = trig_reg;
   assign gpio_active = gpio_en;

   // ---------------------------------------------------------------
   // blink pattern
   // ---------------------------------------------------------------
   // counts oscillator ticks; free-running so blink phase is not
   // tied to when the flags rise
   logic [BLINK_CNT_W-1:0] blink_cnt_reg, blink_cnt_next;
   logic osc_prev_reg, osc_prev_next;
   logic [1:0] osc_sync_reg, osc_sync_next;
   logic osc_tick;

   always_comb begin
      osc_sync_next = {osc_sync_reg[0], kilohertz_oscillator};
      osc_prev_next = osc_sync_reg[1];
      blink_cnt_next = blink_cnt_reg;
      if (osc_tick) begin
         blink_cnt_next = (blink_cnt_reg == BLINK_LAST_CNT) ? '0 :
                          BLINK_CNT_W'(blink_cnt_reg + 1'b1);
      end
   end

   assign osc_tick = osc_sync_reg[1] & ~osc_prev_reg;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         osc_sync_reg <= 2'h0;
         osc_prev_reg <= 1'b0;
         blink_cnt_reg <= '0;
      end else begin
         osc_sync_reg <= osc_sync_next;
         osc_prev_reg <= osc_prev_next;
         blink_cnt_reg <= blink_cnt_next;
      end
   end

   // ---------------------------------------------------------------
   // output pin
   // ---------------------------------------------------------------
   logic src;
   logic flag_or;
   logic out_next, oe_next, opu_next, opd_next;
   logic out_reg, oe_reg, opu_reg, opd_reg;

   assign flag_or = |error_flags;

   always_comb begin
      unique case (config_reg.output_source_select)
         SRC_COMPARATOR: src = comp_s;
         SRC_RF_COMMAND: src = rf_command_busy;
         SRC_RF_FIELD: src = field_s;
         SRC_ERROR_FLAGS: src = flag_or & (~blink_enable | (blink_cnt_reg < BLINK_HIGH_CNT));
      endcase
   end

   always_comb begin
      out_next = 1'b0;
      oe_next = 1'b0;
      opu_next = 1'b0;
      opd_next = 1'b0;
      if (ce_s) begin
         out_next = spi_dout_data;
         oe_next = spi_dout_oe;
      end else if (!serial_mode_lock && application_mode) begin
         unique case (config_reg.output_pin_drive)
            DRIVE_PUSH_PULL: begin
               out_next = src;
               oe_next = 1'b1;
            end
            DRIVE_PULL_UP: begin
               opu_next = 1'b1;
               oe_next = ~src;
            end
            DRIVE_PULL_DOWN: begin
               opd_next = 1'b1;
               out_next = 1'b1;
               oe_next = ~src;
            end
            DRIVE_HIGH_Z: begin
               oe_next = 1'b0;
            end
         endcase
      end else begin
         // locked in serial mode or outside application mode while deselected: serial output copy
         out_next = spi_dout_data;
         oe_next = spi_dout_oe;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         out_reg <= 1'b0;
         oe_reg <= 1'b0;
         opu_reg <= 1'b0;
         opd_reg <= 1'b0;
      end else begin
         out_reg <= out_next;
         oe_reg <= oe_next;
         opu_reg <= opu_next;
         opd_reg <= opd_next;
      end
   end

   assign dout_o = out_reg;
   assign dout_oe = oe_reg;
   assign dout_pullup_en = opu_reg;
   assign dout_pulldown_en = opd_reg;

endmodule

// ==== verification/spi_pin_gpio_monitor.sv ====
`timescale 1ns/10ps
module spi_pin_gpio_monitor
   import gpio_pin_pkg::*;
(
   input wire logic core_clk, resetn, cfg_wr_en, cfg_rd_en, cfg_rvalid,
   input wire logic [gpio_pin_pkg::ADDR_W-1:0] cfg_addr,
   input wire logic [7:0] cfg_wdata, cfg_rdata,
   input wire logic gpio_active, application_mode, logging_event_busy, blink_enable,
   input wire gpio_pin_pkg::logger_state_e logger_state,
   input wire logic timed_start_enable, start_delay_expired, rf_command_busy,
   input wire gpio_pin_pkg::error_flags_s error_flags,
   input wire logic spi_dout_data, spi_dout_oe, din_pullup_en, din_pulldown_en,
   input wire logic dout_o, dout_oe, dout_pullup_en, dout_pulldown_en,
   input wire logic start_logging, log_event_trigger
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (!resetn);
   // ------
   // config shadow
   // ------
   logic [7:0] cfg_q;
   logic sv, ok, pu;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= GPIO_PIN_CONFIG_RESET;
      end else if (cfg_wr_en && cfg_addr == GPIO_PIN_CONFIG_ADDR) begin
         cfg_q <= cfg_wdata;
      end
   end
   // synced sources lag by two edges, so only same-domain ones are judged here
   assign sv = (cfg_q[7:6] == SRC_RF_COMMAND) ? rf_command_busy : |error_flags;
   assign ok = gpio_active && application_mode && (cfg_q[7:6] == SRC_RF_COMMAND
      || cfg_q[7:6] == SRC_ERROR_FLAGS && !blink_enable);
   assign pu = (cfg_q[1:0] == IN_MODE_EVENT_PULLUP) ? logging_event_busy
      : (cfg_q[1:0] == IN_MODE_START) ? logger_state == LOGGER_WAIT
      : (cfg_q[1:0] == IN_MODE_TRIGGER) && logger_state == LOGGER_RUNNING;
   read_answer_a: assert property (cfg_rd_en |=> cfg_rvalid && cfg_rdata ==
      ($past(cfg_addr) == GPIO_PIN_CONFIG_ADDR ? $past(cfg_q) : 8'h00))
      else $error("config read answer wrong");
   spi_pass_a: assert property (!gpio_active |=> dout_o == $past(spi_dout_data)
      && dout_oe == $past(spi_dout_oe))
      else $error("serial output not passed through");
   push_pull_a: assert property (ok && cfg_q[5:4] == DRIVE_PUSH_PULL |=>
      dout_oe && dout_o == $past(sv))
      else $error("push-pull output wrong");
   pull_up_a: assert property (ok && cfg_q[5:4] == DRIVE_PULL_UP |=>
      dout_pullup_en && !dout_o && dout_oe == !$past(sv))
      else $error("pull-up output wrong");
   pull_down_a: assert property (ok && cfg_q[5:4] == DRIVE_PULL_DOWN |=>
      dout_pulldown_en && dout_o && dout_oe == !$past(sv))
      else $error("pull-down output wrong");
   din_pull_a: assert property (gpio_active |=> din_pullup_en == $past(pu) &&
      din_pulldown_en == ($past(cfg_q[1:0]) == IN_MODE_PULLDOWN))
      else $error("input pin pull wrong");
   timed_start_a: assert property (gpio_active && cfg_q[1:0] == IN_MODE_START &&
      logger_state == LOGGER_WAIT && timed_start_enable && start_delay_expired
      |=> start_logging)
      else $error("timed start missing");
   trigger_once_a: assert property (log_event_trigger |=> !log_event_trigger)
      else $error("event trigger longer than one cycle");
endmodule
bind spi_pin_gpio_control spi_pin_gpio_monitor spi_pin_gpio_monitor_inst (
   .core_clk(core_clk), .resetn(resetn), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en),
   .cfg_rvalid(cfg_rvalid), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
   .cfg_rdata(cfg_rdata), .gpio_active(gpio_active), .application_mode(application_mode),
   .logging_event_busy(logging_event_busy), .blink_enable(blink_enable),
   .logger_state(logger_state), .timed_start_enable(timed_start_enable),
   .start_delay_expired(start_delay_expired), .rf_command_busy(rf_command_busy),
   .error_flags(error_flags), .spi_dout_data(spi_dout_data), .spi_dout_oe(spi_dout_oe),
   .din_pullup_en(din_pullup_en), .din_pulldown_en(din_pulldown_en), .dout_o(dout_o),
   .dout_oe(dout_oe), .dout_pullup_en(dout_pullup_en), .dout_pulldown_en(dout_pulldown_en),
   .start_logging(start_logging), .log_event_trigger(log_event_trigger)
);

// ==== verification/pin_model.sv ====
`timescale 1ns/10ps
module pin_model (
   input wire logic core_clk, drv_en, drv_val, din_pullup_en, din_pulldown_en,
   input wire logic dout_o, dout_oe, dout_pullup_en, dout_pulldown_en,
   output logic din_pin, dout_level
);
   logic flip = 1'b0;
   // a floating node wanders, so a stale level never passes for a pull
   always @(posedge core_clk) begin
      flip <= !flip;
   end
   assign din_pin = drv_en ? drv_val : din_pullup_en ? 1'b1 : din_pulldown_en ? 1'b0 : flip;
   assign dout_level = dout_oe ? dout_o : dout_pullup_en ? 1'b1 : dout_pulldown_en ? 1'b0 : flip;
endmodule

// ==== verification/tb_spi_pin_gpio_control.sv ====
`timescale 1ns/10ps
module tb_spi_pin_gpio_control;
   import gpio_pin_pkg::*;
   logic core_clk = 1'b0, resetn = 1'b0, wr_en = 1'b0, rd_en = 1'b0, rvalid, ce = 1'b0;
   logic [ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = '0, rdata;
   logic lock = 1'b0, app = 1'b1, busy = 1'b0, tmr = 1'b0, dly = 1'b0, blink = 1'b0;
   logic osc = 1'b0, cmp = 1'b0, rfc = 1'b0, rff = 1'b0, sdat = 1'b0, soe = 1'b0;
   logic den = 1'b1, dval = 1'b1, din, pu, pd, d_o, d_oe, d_pu, d_pd, st, trig, act, lvl;
   logger_state_e lst = LOGGER_OTHER;
   error_flags_s flags = '0;
   int err_count = 0, compares = 0, ns = 0, nt = 0, n, n0;
   // {mode, state, busy, pull-up, pull-down}
   logic [6:0] pulls [7] = '{7'b0000001, 7'b0100000, 7'b0100110, 7'b1001010,
      7'b1010000, 7'b1110010, 7'b1101000};
   // {mode, state, ce, falls, starts, triggers}
   logic [10:0] edges [5] = '{11'b11100100010, 11'b11010010000, 11'b10010010100,
      11'b10011010000, 11'b10100010000};
   spi_pin_gpio_control spi_pin_gpio_control_inst (
      .core_clk(core_clk), .resetn(resetn), .cfg_wr_en(wr_en), .cfg_rd_en(rd_en),
      .cfg_addr(addr), .cfg_wdata(wdata), .cfg_rdata(rdata), .cfg_rvalid(rvalid),
      .chip_enable_pin(ce), .serial_mode_lock(lock), .application_mode(app),
      .logger_state(lst), .logging_event_busy(busy), .timed_start_enable(tmr),
      .start_delay_expired(dly), .blink_enable(blink), .kilohertz_oscillator(osc),
      .comparator_out(cmp), .rf_command_busy(rfc), .rf_field_present(rff),
      .error_flags(flags), .spi_dout_data(sdat), .spi_dout_oe(soe), .din_pin(din),
      .din_pullup_en(pu), .din_pulldown_en(pd), .dout_o(d_o), .dout_oe(d_oe),
      .dout_pullup_en(d_pu), .dout_pulldown_en(d_pd), .start_logging(st),
      .log_event_trigger(trig), .gpio_active(act)
   );
   pin_model pin_model_inst (
      .core_clk(core_clk), .drv_en(den), .drv_val(dval), .din_pullup_en(pu),
      .din_pulldown_en(pd), .dout_o(d_o), .dout_oe(d_oe), .dout_pullup_en(d_pu),
      .dout_pulldown_en(d_pd), .din_pin(din), .dout_level(lvl)
   );
   initial forever #50 core_clk = ~core_clk;
   initial forever #400 osc = ~osc;
   always @(posedge core_clk) begin
      ns += st;
      nt += trig;
   end
   task automatic cyc(input int k);
      repeat (k) @(negedge core_clk);
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] want, input string what);
      compares++;
      if (got !== want) begin
         err_count++;
         $display("Error at %0t: %s got %h want %h", $time, what, got, want);
      end
   endtask
   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr_en = 1'b1;
      cyc(1);
      wr_en = 1'b0;
   endtask
   task automatic rd(input logic [10:0] a, input logic [7:0] want);
      addr = a;
      rd_en = 1'b1;
      cyc(1);
      rd_en = 1'b0;
      check({rvalid, rdata}, {1'b1, want}, "read");
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #2000000;
      err_count++;
      test_done();
   end
   initial begin
      cyc(5);
      resetn = 1'b1;
      cyc(2);
      rd(GPIO_PIN_CONFIG_ADDR, GPIO_PIN_CONFIG_RESET);
      wr(11'h43a, 8'h5a);
      rd(11'h43a, 8'h00);
      rd(GPIO_PIN_CONFIG_ADDR, GPIO_PIN_CONFIG_RESET);
      check(d_oe, 1'b0, "default drive");
      $display("test registers done");
      sdat = 1'b1;
      soe = 1'b1;
      ce = 1'b1;
      cyc(4);
      check({act, d_oe, d_o}, 3'b011, "ce high");
      ce = 1'b0;
      lock = 1'b1;
      cyc(4);
      check({act, d_oe, d_o}, 3'b011, "locked");
      lock = 1'b0;
      app = 1'b0;
      cyc(4);
      check({act, d_oe, d_o}, 3'b111, "no application mode");
      app = 1'b1;
      $display("test passthrough done");
      for (int d = 0; d < 3; d++) begin
         for (int s = 0; s < 4; s++) begin
            for (int b = 0; b < 2; b++) begin
               wr(GPIO_PIN_CONFIG_ADDR, {s[1:0], d[1:0], 4'h0});
               cmp = b[0] ^ (s != 0);
               rfc = b[0] ^ (s != 1);
               rff = b[0] ^ (s != 2);
               flags = {2'b00, b[0] ^ (s != 3), 1'b0};
               cyc(5);
               check(lvl, b[0] ^ (d == 2), "dout level");
            end
         end
      end
      $display("test drive and source done");
      wr(GPIO_PIN_CONFIG_ADDR, 8'hc0);
      flags = 4'h1;
      blink = 1'b1;
      cyc(20);
      n = 0;
      // one full blink period of eight-cycle oscillator periods holds a fixed high count
      repeat (BLINK_PERIOD * 8) begin
         cyc(1);
         n += d_o;
      end
      check(16'(n), 16'(BLINK_HIGH_COUNTS * 8), "blink high cycles");
      blink = 1'b0;
      $display("test blink done");
      den = 1'b0;
      foreach (pulls[i]) begin
         wr(GPIO_PIN_CONFIG_ADDR, {6'h00, pulls[i][6:5]});
         lst = logger_state_e'(pulls[i][4:3]);
         busy = pulls[i][2];
         cyc(2);
         check({pu, pd}, pulls[i][1:0], "din pulls");
      end
      den = 1'b1;
      busy = 1'b0;
      $display("test input pulls done");
      foreach (edges[i]) begin
         wr(GPIO_PIN_CONFIG_ADDR, {6'h00, edges[i][10:9]});
         lst = logger_state_e'(edges[i][8:7]);
         ce = edges[i][6];
         cyc(4);
         // snapshots keep the pulse counters owned by their counting process
         n = ns;
         n0 = nt;
         repeat (edges[i][5:4]) begin
            dval = 1'b0;
            cyc(3);
            dval = 1'b1;
            cyc(3);
         end
         cyc(4);
         check({2'(ns - n), 2'(nt - n0)}, edges[i][3:0], "din edges");
      end
      ce = 1'b0;
      for (int t = 0; t < 2; t++) begin
         wr(GPIO_PIN_CONFIG_ADDR, {6'h00, IN_MODE_START});
         lst = LOGGER_WAIT;
         tmr = t[0];
         cyc(2);
         n = ns;
         dly = 1'b1;
         cyc(1);
         dly = 1'b0;
         cyc(3);
         check(16'(ns - n), 16'(t), "timed start");
      end
      $display("test input edges done");
      // mid-run reset must bring back the default config byte
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
      cyc(2);
      rd(GPIO_PIN_CONFIG_ADDR, GPIO_PIN_CONFIG_RESET);
      check(d_oe, 1'b0, "drive after reset");
      $display("test reset done");
      test_done();
   end
endmodule
